// ### shared/sarseq_pkg.sv
// shared constants and state encoding for the sar converter sequencer
// assumes one system clock; slower rates arrive as enable pulses
package sarseq_pkg;

    // sequencer states, gray along idle -> power-up -> track -> convert -> idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_PWRUP = 2'h1,
        ST_TRACK = 2'h3,
        ST_CONV  = 2'h2
    } sarseq_state_t;

    // convert-start source codes
    localparam logic [1:0] SRC_BUSY = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    localparam logic [1:0] SRC_TMR1 = 2'h2;
    localparam logic [1:0] SRC_TMR2 = 2'h3;

    // tracking mode codes; 00 behaves as post-tracking
    localparam logic [1:0] TRK_POST = 2'h1;
    localparam logic [1:0] TRK_PRE = 2'h2;
    localparam logic [1:0] TRK_DUAL = 2'h3;

    // repeat count codes
    localparam logic [1:0] RPT_1 = 2'h0;
    localparam logic [1:0] RPT_4 = 2'h1;
    localparam logic [1:0] RPT_8 = 2'h2;
    localparam logic [1:0] RPT_16 = 2'h3;

    // timing counts in subsystem or sar clock ticks
    localparam logic [5:0] TRACK_EXTRA = 6'h02;
    localparam logic [5:0] PWRUP_EXTRA = 6'h01;
    localparam logic [5:0] SAR_CYCLES = 6'h0d;

    // conversion phases: lead conv_subsystem_clk tick, sar steps, trail conv_subsystem_clk tick
    localparam logic [1:0] PH_LEAD = 2'h0;
    localparam logic [1:0] PH_SAR = 2'h1;
    localparam logic [1:0] PH_TRAIL = 2'h2;

    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [4:0] DIV_RST = 5'h00;

endpackage : sarseq_pkg

// ### logic/sarseq_sar_div.sv
// sar clock divider: one sar tick per (ratio + 1) subsystem ticks
// assumes conv_subsystem_clk_en is a one-cycle enable on clk; run low restarts the count
module sarseq_sar_div (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic conv_subsystem_clk_en,
    input wire logic run,
    input wire logic [4:0] ratio,
    output logic sar_tick
);

    typedef struct packed {
        logic [4:0] cnt;
    } sarseq_div_t;

    sarseq_div_t s_q;
    sarseq_div_t s_d;

    // tick on the last subsystem tick of each divided period
    assign sar_tick = run && conv_subsystem_clk_en && (s_q.cnt == ratio);

    // restart on every run so the first sar step is a full period long
    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.cnt = sarseq_pkg::DIV_RST;
        end else if (conv_subsystem_clk_en) begin
            s_d.cnt = sar_tick ? sarseq_pkg::DIV_RST : 5'(s_q.cnt + 5'h01);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sarseq_sar_div

// ### logic/sarseq_core.sv
// convert-start selection, tracking, conversion timing, burst and accumulation
// assumes all inputs synchronous to clk; burst_osc_tick is the oscillator as an enable
module sarseq_core (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic conv_power_on,
    input wire logic [1:0] start_source_sel,
    input wire logic busy_write,
    input wire logic ext_convert_start,
    input wire logic timer1_ovf,
    input wire logic timer2_low_ovf,
    input wire logic timer2_high_ovf,
    input wire logic timer2_split8,
    input wire logic [1:0] track_mode_sel,
    input wire logic [3:0] track_time_sel,
    input wire logic burst_mode_on,
    input wire logic burst_osc_tick,
    input wire logic [4:0] sar_clk_divider,
    input wire logic [4:0] powerup_wait_sel,
    input wire logic [1:0] repeat_count_sel,
    input wire logic left_justify_sel,
    input wire logic eoc_irq_en,
    input wire logic done_clear,
    input wire logic [11:0] adc_sample,
    output logic conv_powered,
    output logic sample_connect,
    output logic conv_in_progress,
    output logic sar_step,
    output logic conv_done_flag,
    output logic eoc_irq_req,
    output logic window_cmp_go,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte
);

    typedef struct packed {
        sarseq_pkg::sarseq_state_t st;
        logic [5:0] cnt;
        logic [1:0] cph;
        logic [4:0] nsamp;
        logic [15:0] acc;
        logic [15:0] res;
        logic flag;
        logic wc;
        logic [2:0] pin;
    } sarseq_regs_t;

    sarseq_regs_t s_q;
    sarseq_regs_t s_d;

    // number of samples in one series
    function automatic logic [4:0] rpt_len(input logic [1:0] sel);
        case (sel)
            sarseq_pkg::RPT_1: rpt_len = 5'h01;
            sarseq_pkg::RPT_4: rpt_len = 5'h04;
            sarseq_pkg::RPT_8: rpt_len = 5'h08;
            sarseq_pkg::RPT_16: rpt_len = 5'h10;
            default: rpt_len = 5'h01;
        endcase
    endfunction : rpt_len

    // timer 2 overflow follows the timer's width
    function automatic logic tmr2_ovf(input logic split8, input logic lo, input logic hi);
        tmr2_ovf = split8 ? lo : hi;
    endfunction : tmr2_ovf

    logic conv_subsystem_clk_en;
    logic pin_rise;
    logic start_evt;
    logic timed_track;
    logic idle_on;
    logic [4:0] len;
    logic [5:0] trk_len;
    logic [5:0] pwr_len;
    logic [15:0] acc_sum;
    logic last_sample;

    // subsystem clock rate as an enable: every cycle, or the burst oscillator tick
    assign conv_subsystem_clk_en = burst_mode_on ? burst_osc_tick : 1'b1;

    // pin edge taken after the second sync stage only
    assign pin_rise = s_q.pin[1] && !s_q.pin[2];

    // start source mux
    always_comb begin
        case (start_source_sel)
            sarseq_pkg::SRC_BUSY: start_evt = busy_write;
            sarseq_pkg::SRC_PIN: start_evt = pin_rise;
            sarseq_pkg::SRC_TMR1: start_evt = timer1_ovf;
            sarseq_pkg::SRC_TMR2: start_evt = tmr2_ovf(timer2_split8, timer2_low_ovf, timer2_high_ovf);
            default: start_evt = 1'b0;
        endcase
    end

    // pre-tracking is never used in burst; a stray setting falls back to the timed track interval, with sample_connect held low
    assign timed_track = burst_mode_on || (track_mode_sel != sarseq_pkg::TRK_PRE);
    assign idle_on = conv_power_on;
    assign len = rpt_len(repeat_count_sel);
    assign trk_len = 6'({2'h0, track_time_sel}) + sarseq_pkg::TRACK_EXTRA;
    assign pwr_len = 6'({1'b0, powerup_wait_sel}) + sarseq_pkg::PWRUP_EXTRA;
    assign acc_sum = 16'(s_q.acc + {4'h0, adc_sample});
    assign last_sample = (5'(s_q.nsamp + 5'h01) == len);

    sarseq_sar_div u_div (
        .clk(clk),
        .arst_n(arst_n),
        .conv_subsystem_clk_en(conv_subsystem_clk_en),
        .run(s_q.st == sarseq_pkg::ST_CONV && s_q.cph == sarseq_pkg::PH_SAR),
        .ratio(sar_clk_divider),
        .sar_tick(sar_step)
    );

    // sequencer; starts while busy are ignored
    always_comb begin
        s_d = s_q;
        s_d.wc = 1'b0;
        s_d.pin = {s_q.pin[1:0], ext_convert_start};
        case (s_q.st)
            sarseq_pkg::ST_IDLE: begin
                // normal mode needs the enable; burst powers itself up
                if (start_evt && (burst_mode_on || conv_power_on)) begin
                    s_d.cnt = 6'h00;
                    s_d.cph = sarseq_pkg::PH_LEAD;
                    if (burst_mode_on || s_q.nsamp == 5'h00) begin
                        s_d.acc = 16'h0000;
                        s_d.nsamp = 5'h00;
                    end
                    if (burst_mode_on && !idle_on) begin
                        s_d.st = sarseq_pkg::ST_PWRUP;
                    end else if (timed_track) begin
                        s_d.st = sarseq_pkg::ST_TRACK;
                    end else begin
                        s_d.st = sarseq_pkg::ST_CONV;
                    end
                end
            end
            sarseq_pkg::ST_PWRUP: begin
                if (conv_subsystem_clk_en) begin
                    s_d.cnt = 6'(s_q.cnt + 6'h01);
                    if (6'(s_q.cnt + 6'h01) == pwr_len) begin
                        s_d.cnt = 6'h00;
                        s_d.st = sarseq_pkg::ST_TRACK;
                    end
                end
            end
            sarseq_pkg::ST_TRACK: begin
                if (conv_subsystem_clk_en) begin
                    s_d.cnt = 6'(s_q.cnt + 6'h01);
                    if (6'(s_q.cnt + 6'h01) == trk_len) begin
                        s_d.cnt = 6'h00;
                        s_d.cph = sarseq_pkg::PH_LEAD;
                        s_d.st = sarseq_pkg::ST_CONV;
                    end
                end
            end
            sarseq_pkg::ST_CONV: begin
                // one lead tick, 13 sar steps, one trail tick
                case (s_q.cph)
                    sarseq_pkg::PH_LEAD: begin
                        if (conv_subsystem_clk_en) begin
                            s_d.cph = sarseq_pkg::PH_SAR;
                        end
                    end
                    sarseq_pkg::PH_SAR: begin
                        if (sar_step) begin
                            s_d.cnt = 6'(s_q.cnt + 6'h01);
                            if (6'(s_q.cnt + 6'h01) == sarseq_pkg::SAR_CYCLES) begin
                                s_d.cnt = 6'h00;
                                s_d.cph = sarseq_pkg::PH_TRAIL;
                            end
                        end
                    end
                    default: begin
                        if (conv_subsystem_clk_en) begin
                            s_d.acc = acc_sum;
                            s_d.nsamp = 5'(s_q.nsamp + 5'h01);
                            s_d.cph = sarseq_pkg::PH_LEAD;
                            s_d.st = sarseq_pkg::ST_IDLE;
                            if (last_sample) begin
                                s_d.nsamp = 5'h00;
                                s_d.wc = 1'b1;
                                s_d.flag = 1'b1;
                                // summed series are always right-justified
                                if (len != 5'h01) begin
                                    s_d.res = acc_sum;
                                end else if (left_justify_sel) begin
                                    s_d.res = {adc_sample, 4'h0};
                                end else begin
                                    s_d.res = {4'h0, adc_sample};
                                end
                            end else if (burst_mode_on) begin
                                s_d.st = sarseq_pkg::ST_TRACK;
                            end
                        end
                    end
                endcase
            end
            default: s_d.st = sarseq_pkg::ST_IDLE;
        endcase
        // a completion in the clear cycle keeps the flag set
        if (done_clear && !(s_d.flag && !s_q.flag)) begin
            s_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // power and sampling switch; busy covers the whole burst series
    assign conv_in_progress = (s_q.st != sarseq_pkg::ST_IDLE);
    assign conv_powered = conv_power_on || conv_in_progress;
    always_comb begin
        case (track_mode_sel)
            sarseq_pkg::TRK_PRE: sample_connect = conv_powered && s_q.st != sarseq_pkg::ST_CONV && !burst_mode_on;
            sarseq_pkg::TRK_DUAL: sample_connect = s_q.st == sarseq_pkg::ST_TRACK
                || (s_q.st == sarseq_pkg::ST_IDLE && conv_powered);
            default: sample_connect = s_q.st == sarseq_pkg::ST_TRACK;
        endcase
    end

    assign conv_done_flag = s_q.flag;
    assign eoc_irq_req = s_q.flag && eoc_irq_en;
    assign window_cmp_go = s_q.wc;
    assign result_high_byte = s_q.res[15:8];
    assign result_low_byte = s_q.res[7:0];

    // helper counters for the checks below
    logic [5:0] chk_trk;
    logic [5:0] chk_sar;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_trk <= 6'h00;
            chk_sar <= 6'h00;
        end else begin
            chk_trk <= (s_q.st == sarseq_pkg::ST_TRACK) ? 6'(chk_trk + {5'h00, conv_subsystem_clk_en}) : 6'h00;
            chk_sar <= (s_q.st == sarseq_pkg::ST_CONV) ? 6'(chk_sar + {5'h00, sar_step}) : 6'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_power_idle: assert property (!conv_power_on && !conv_in_progress |-> !conv_powered)
        else $error("converter powered while disabled and idle");
    chk_flag_on_fall: assert property ($rose(conv_done_flag) |-> $past(conv_in_progress) && !conv_in_progress)
        else $error("done flag rose without busy falling");
    chk_pre_direct: assert property (s_q.st == sarseq_pkg::ST_IDLE && start_evt && conv_power_on && !burst_mode_on
        && track_mode_sel == sarseq_pkg::TRK_PRE |=> s_q.st == sarseq_pkg::ST_CONV)
        else $error("pre-tracking start did not convert at once");
    chk_post_open: assert property (track_mode_sel == sarseq_pkg::TRK_POST && s_q.st != sarseq_pkg::ST_TRACK
        |-> !sample_connect)
        else $error("post-tracking capacitor connected outside tracking");
    chk_dual_track: assert property (track_mode_sel == sarseq_pkg::TRK_DUAL && !conv_in_progress && conv_powered
        |-> sample_connect)
        else $error("dual-tracking not tracking while idle");
    chk_track_len: assert property (s_q.st == sarseq_pkg::ST_TRACK && s_d.st == sarseq_pkg::ST_CONV
        |-> 6'(chk_trk + 6'h01) == trk_len)
        else $error("tracking interval length wrong");
    chk_sar_count: assert property (s_q.st == sarseq_pkg::ST_CONV && s_d.st != sarseq_pkg::ST_CONV
        |-> chk_sar == sarseq_pkg::SAR_CYCLES)
        else $error("conversion did not take 13 sar steps");
    chk_burst_wake: assert property (s_q.st == sarseq_pkg::ST_IDLE && start_evt && burst_mode_on && !conv_power_on
        |=> s_q.st == sarseq_pkg::ST_PWRUP ##1 conv_powered)
        else $error("burst start from power-down skipped power-up");
    chk_window_gate: assert property (window_cmp_go |-> conv_done_flag && $fell(conv_in_progress))
        else $error("window compare before series complete");
    chk_series_len: assert property (window_cmp_go |-> $past(s_q.nsamp) == 5'(len - 5'h01))
        else $error("series ended at wrong sample count");

    cov_burst_16: cover property (burst_mode_on && repeat_count_sel == sarseq_pkg::RPT_16 && $rose(conv_done_flag));
    cov_pre_conv: cover property (track_mode_sel == sarseq_pkg::TRK_PRE && $rose(conv_done_flag));
    cov_pin_start: cover property (start_source_sel == sarseq_pkg::SRC_PIN && pin_rise);
    cov_clear_race: cover property (done_clear && $rose(conv_done_flag));

endmodule : sarseq_core

// ### sim/sarseq_far_model.sv
// far-side model: software start writes, timer overflows and the start pin
// assumes the bench raises req for one clock; every output changes on the falling edge
module sarseq_far_model (
    input wire logic clk,
    input wire logic req,
    input wire logic wrong,
    input wire logic [1:0] src,
    input wire logic split8,
    output logic busy_write,
    output logic ext_convert_start,
    output logic timer1_ovf,
    output logic timer2_low_ovf,
    output logic timer2_high_ovf
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_q = 1'b0;
    logic [1:0] eff;
    logic half8;
    int pin_hold = 0;

    // quiet outputs until the first request
    initial begin
        {busy_write, ext_convert_start, timer1_ovf, timer2_low_ovf, timer2_high_ovf} = 5'h00;
    end

    // request is taken on the rising edge, acted on at the next falling edge
    always @(posedge clk) begin
        req_q <= req;
    end

    // pin drops low for two cycles before each new edge, so a held pin never hides an edge
    // each output is written once per edge, so a pulse never depends on assignment order
    always @(negedge clk) begin
        // wrong mode hits an unselected source, or the unused timer 2 half
        eff = (wrong && src != sarseq_pkg::SRC_TMR2) ? 2'(src + 2'h1) : src;
        half8 = split8 ^ wrong;
        busy_write <= req_q && (eff == sarseq_pkg::SRC_BUSY);
        timer1_ovf <= req_q && (eff == sarseq_pkg::SRC_TMR1);
        timer2_low_ovf <= req_q && (eff == sarseq_pkg::SRC_TMR2) && half8;
        timer2_high_ovf <= req_q && (eff == sarseq_pkg::SRC_TMR2) && !half8;
        ext_convert_start <= (pin_hold > 1) && (pin_hold < 63);
        pin_hold <= (req_q && eff == sarseq_pkg::SRC_PIN) ? 64 : ((pin_hold > 0) ? pin_hold - 1 : 0);
    end
endmodule : sarseq_far_model

// ### sim/testbench.sv
// self-checking bench for the converter sequencer with random configurations
// assumes sarseq_core and the far-side model; inputs move on the falling edge
`define CHECK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin fail_count++; $display("BAD %0t %s", $time, msg); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic conv_power_on = 1'b0;
    logic [1:0] start_source_sel = 2'h0;
    logic timer2_split8 = 1'b0;
    logic [1:0] track_mode_sel = 2'h1;
    logic [3:0] track_time_sel = 4'h0;
    logic burst_mode_on = 1'b0;
    logic burst_osc_tick = 1'b1;
    logic [4:0] sar_clk_divider = 5'h00;
    logic [4:0] powerup_wait_sel = 5'h00;
    logic [1:0] repeat_count_sel = 2'h0;
    logic left_justify_sel = 1'b0;
    logic eoc_irq_en = 1'b0;
    logic done_clear = 1'b0;
    logic [11:0] adc_sample = 12'h000;
    logic req = 1'b0;
    logic wrong = 1'b0;
    logic tick_rand = 1'b0;
    logic [31:0] seed = 32'h30d8bf05;
    logic busy_write, ext_convert_start, timer1_ovf, timer2_low_ovf, timer2_high_ovf;
    logic conv_powered, sample_connect, conv_in_progress, sar_step, conv_done_flag, eoc_irq_req, window_cmp_go;
    logic [7:0] result_high_byte, result_low_byte;
    int fail_count = 0;
    int checked = 0;

    sarseq_core sarseq_core_inst (.clk(clk), .arst_n(arst_n), .conv_power_on(conv_power_on),
        .start_source_sel(start_source_sel), .busy_write(busy_write), .ext_convert_start(ext_convert_start),
        .timer1_ovf(timer1_ovf), .timer2_low_ovf(timer2_low_ovf), .timer2_high_ovf(timer2_high_ovf),
        .timer2_split8(timer2_split8), .track_mode_sel(track_mode_sel), .track_time_sel(track_time_sel),
        .burst_mode_on(burst_mode_on), .burst_osc_tick(burst_osc_tick), .sar_clk_divider(sar_clk_divider),
        .powerup_wait_sel(powerup_wait_sel), .repeat_count_sel(repeat_count_sel),
        .left_justify_sel(left_justify_sel), .eoc_irq_en(eoc_irq_en), .done_clear(done_clear),
        .adc_sample(adc_sample), .conv_powered(conv_powered), .sample_connect(sample_connect),
        .conv_in_progress(conv_in_progress), .sar_step(sar_step), .conv_done_flag(conv_done_flag),
        .eoc_irq_req(eoc_irq_req), .window_cmp_go(window_cmp_go), .result_high_byte(result_high_byte),
        .result_low_byte(result_low_byte));

    sarseq_far_model sarseq_far_model_inst (.clk(clk), .req(req), .wrong(wrong), .src(start_source_sel),
        .split8(timer2_split8), .busy_write(busy_write), .ext_convert_start(ext_convert_start),
        .timer1_ovf(timer1_ovf), .timer2_low_ovf(timer2_low_ovf), .timer2_high_ovf(timer2_high_ovf));

    function automatic logic [31:0] lfsr(logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // busy span of one conversion when the subsystem tick runs every cycle
    function automatic int exp_busy();
        exp_busy = 4 + track_time_sel + 13 * (sar_clk_divider + 1);
        if (track_mode_sel == sarseq_pkg::TRK_PRE) exp_busy = 2 + 13 * (sar_clk_divider + 1);
        if (burst_mode_on && !conv_power_on) exp_busy += powerup_wait_sel + 1;
    endfunction : exp_busy

    // sum of 1, 4, 8 or 16 equal samples; justification only honoured for one sample
    function automatic logic [15:0] exp_result();
        exp_result = {4'h0, adc_sample} << ((repeat_count_sel == sarseq_pkg::RPT_1) ? 0 : repeat_count_sel + 1);
        if (repeat_count_sel == sarseq_pkg::RPT_1 && left_justify_sel) exp_result = {adc_sample, 4'h0};
    endfunction : exp_result

    task automatic test_done();
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    // one start, watched until busy falls, then a quiet spell and a flag clear
    task automatic one_start(input bit last, input int nconv);
        int busy_n;
        int steps;
        int gap;
        int w;
        busy_n = 0;
        steps = 0;
        gap = 0;
        w = 0;
        @(negedge clk) req <= 1'b1;
        @(negedge clk) req <= 1'b0;
        while (conv_in_progress !== 1'b1 && w < 20) begin
            @(negedge clk);
            w++;
        end
        // look just after the falling edge, once the oscillator tick for the next edge has settled
        #1;
        `CHECK(conv_in_progress, 1'b1, "start missed")
        `CHECK(sample_connect, (track_mode_sel != sarseq_pkg::TRK_PRE) && !(burst_mode_on && !conv_power_on), "first phase")
        while (conv_in_progress === 1'b1 && busy_n < 9000) begin
            `CHECK(conv_powered, 1'b1, "unpowered while busy")
            `CHECK(conv_done_flag, 1'b0, "early flag")
            `CHECK(window_cmp_go, 1'b0, "early compare")
            if (sar_step === 1'b1) begin
                if (burst_mode_on) `CHECK(burst_osc_tick, 1'b1, "step off burst tick")
                else if (steps > 0) `CHECK(gap, sar_clk_divider + 1, "sar spacing")
                steps++;
                gap = 0;
            end
            gap++;
            busy_n++;
            @(negedge clk);
            #1;
        end
        `CHECK(steps, 13 * nconv, "sar step count")
        if (nconv == 1 && !(tick_rand && burst_mode_on)) `CHECK(busy_n, exp_busy(), "busy length")
        `CHECK(conv_done_flag, last, "done flag")
        `CHECK(window_cmp_go, last, "compare go")
        `CHECK(eoc_irq_req, last & eoc_irq_en, "irq request")
        `CHECK(conv_powered, conv_power_on, "idle power")
        `CHECK(sample_connect, track_mode_sel[1] && conv_power_on, "idle tracking")
        if (last) `CHECK({result_high_byte, result_low_byte}, exp_result(), "result")
        repeat (12) begin
            @(negedge clk);
            `CHECK(conv_in_progress, 1'b0, "extra start")
            `CHECK(window_cmp_go, 1'b0, "long compare pulse")
        end
        done_clear <= 1'b1;
        @(negedge clk) done_clear <= 1'b0;
        `CHECK(conv_done_flag, 1'b0, "flag clear")
    endtask : one_start

    // a start that must be dropped
    task automatic no_start();
        @(negedge clk) req <= 1'b1;
        @(negedge clk) req <= 1'b0;
        repeat (24) begin
            @(negedge clk);
            `CHECK(conv_in_progress, 1'b0, "refused start ran")
        end
    endtask : no_start

    // free-running clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    // random source; it also thins out the oscillator ticks, which only burst mode may follow
    always @(negedge clk) begin
        seed <= lfsr(seed);
        burst_osc_tick <= tick_rand ? seed[7] : 1'b1;
    end

    // the whole run is far below this span; a hang lands here
    initial begin
        #380000;
        fail_count++;
        test_done();
    end

    // main sequence: first half normal mode, second half burst mode
    initial begin
        logic [31:0] r;
        int nstart;
        repeat (3) @(negedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        `CHECK({result_high_byte, result_low_byte}, sarseq_pkg::RESULT_RST, "reset result")
        `CHECK(conv_done_flag, 1'b0, "reset flag")
        for (int i = 0; i < 32; i++) begin
            r = seed;
            start_source_sel <= 2'(i);
            burst_mode_on <= (i >= 16);
            track_mode_sel <= (i >= 16) ? {r[31], 1'b1} : r[31:30];
            track_time_sel <= r[3:0];
            sar_clk_divider <= (i == 7) ? 5'h1f : {3'h0, r[5:4]};
            powerup_wait_sel <= r[11:7];
            repeat_count_sel <= r[13:12];
            left_justify_sel <= r[14];
            eoc_irq_en <= r[15];
            adc_sample <= (i == 3) ? 12'hfff : r[27:16];
            tick_rand <= r[28];
            timer2_split8 <= r[29];
            conv_power_on <= (i >= 16) ? r[30] : 1'b1;
            nstart = (i >= 16 || r[13:12] == 2'h0) ? 1 : (2 << r[13:12]);
            wrong <= 1'b1;
            no_start();
            wrong <= 1'b0;
            for (int k = 0; k < nstart; k++) one_start(k == nstart - 1, (i >= 16) ? nstart * 0 + (r[13:12] == 2'h0 ? 1 : (2 << r[13:12])) : 1);
        end
        burst_mode_on <= 1'b0;
        conv_power_on <= 1'b0;
        no_start();
        `CHECK(conv_powered, 1'b0, "shutdown")
        test_done();
    end
endmodule : testbench
